//--- hdl/irq_status_cfg.svh
// register offsets, field positions, reset values for the mask/status bank
// assumes inclusion by bare name from the design files
`ifndef IRQ_STATUS_CFG_SVH
`define IRQ_STATUS_CFG_SVH
`define ADDR_INTERRUPT_MASK 4'h1
`define ADDR_LIVE_STATUS 4'h2
`define ADDR_INTEGRITY_STATUS 4'h3
`define MASK_USED_BITS 8'h7D
`define MASK_RESET 8'h00
`define LIVE_STATUS_RESET 8'h00
`define INTEGRITY_RESET 8'h01
`define BIT_WAKE 6
`define BIT_SEC_FAULT 5
`define BIT_PRI_FAULT 4
`define BIT_SUP_WARN 3
`define BIT_SUP_UV 2
`define BIT_THERM 0
`define BIT_PRI_LOW 7
`define BIT_SEC_LOW 6
`define BIT_CORRUPT 7
`define BIT_REG_FAULT 1
`define BIT_REG_READY 0
`define SYNC_STAGES 2
`endif

//--- hdl/irq_status_pkg.sv
// types shared by the mask/status bank
// assumes the cfg header for numeric constants
package irq_status_pkg;
	typedef logic [7:0] reg_byte_t;
	typedef logic [3:0] reg_addr_t;
endpackage

//--- hdl/level_sync_if.sv
// carrier for raw levels into the synchroniser and clean levels out
// assumes one core clock on both ends
`timescale 1ns/1ns
interface level_sync_if #(parameter int WIDTH = 13);
	logic [WIDTH-1:0] raw;
	logic [WIDTH-1:0] clean;
	modport src (output raw, input clean);
	modport snk (input raw, output clean);
endinterface

//--- hdl/level_sync.sv
// per-bit two-stage synchroniser for comparator and pin levels
// assumes levels are asynchronous to i_mclk
`timescale 1ns/1ns
`include "irq_status_cfg.svh"
module level_sync #(
	parameter int WIDTH = 13
) (
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	level_sync_if.snk lv
);
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			logic meta_q;
			logic hold_q;
			always_ff @(posedge i_mclk or posedge i_sys_rst) begin
				if (i_sys_rst) begin
					meta_q <= 1'b0;
					hold_q <= 1'b0;
				end else begin
					meta_q <= lv.raw[g];
					hold_q <= meta_q;
				end
			end
			assign lv.clean[g] = hold_q;
		end
	endgenerate
endmodule

//--- hdl/irq_status_regs.sv
// interrupt mask register and two live status registers with irq gating
// assumes the serial port decoder gives one-cycle read/write strobes
//
// What this block does
// - masked set flags never drive the interrupt; unmasked ones other than spare bit 1 still do
// - flags latch on events whatever the mask holds
// - mask bit 6 blocks the wake flag from the interrupt when one
// - mask bits 5 and 4 gate secondary and primary driver fault flags
// - mask bits 3 and 2 gate supply warning and undervoltage flags
// - mask bit 0 gates thermal warning; bits 7 and 1 unused
// - live status is read only, tracks conditions, reads clear nothing
// - status bits 5 and 4 show present secondary/primary driver faults
// - status bit 3 is one while supply is below warning threshold
// - status bit 2 follows undervoltage comparator with its hysteresis
// - status bit 0 follows die temperature warning with hysteresis
// - integrity status is read only and unchanged by reads
// - integrity bit 7 is one when register contents are corrupted
// - corruption disables both drivers and floats receive and logic io
// - corruption forces both regulators on and the clock output running
// - integrity bit 1 is one while the regulator reports any fault
// - integrity bit 0 is one in steady normal regulator operation or while regulator disable is one
// - regulator ready reads one whenever regulator disable is one
// - reading the flag register clears flags once the cause is gone
// - interrupt output, active low, asserts for any set unmasked flag except spare bit 1
// - regulator disable turns the regulator off when one, except while register contents are corrupted
`timescale 1ns/1ns
`include "irq_status_cfg.svh"
module irq_status_regs
	import irq_status_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wr_data,
	output logic [7:0] o_rd_data,
	input wire logic [7:0] i_flags,
	input wire logic i_primary_line_low,
	input wire logic i_secondary_line_low,
	input wire logic i_secondary_driver_fault,
	input wire logic i_primary_driver_fault,
	input wire logic i_supply_below_warning,
	input wire logic i_supply_undervoltage,
	input wire logic i_die_temp_warning,
	input wire logic i_register_corrupted,
	input wire logic i_regulator_fault,
	input wire logic i_regulator_steady,
	input wire logic i_regulator_disable,
	output logic o_irq_n,
	output logic o_drivers_enable,
	output logic o_io_output_enable,
	output logic o_ldo33_force_on,
	output logic o_regulator_enable,
	output logic o_clock_out_force_on
);
	localparam int NSYNC = 11;

	reg_byte_t interrupt_mask_q;
	reg_byte_t live_status;
	reg_byte_t integrity_status;
	reg_byte_t rd_data_d;
	logic irq_n_d;
	logic corrupted;
	logic regulator_disable;

	// ****************************************
	// synchronised levels
	// ****************************************
	level_sync_if #(.WIDTH(NSYNC)) lv();

	assign lv.raw = {i_primary_line_low, i_secondary_line_low,
		i_secondary_driver_fault, i_primary_driver_fault,
		i_supply_below_warning, i_supply_undervoltage,
		i_die_temp_warning, i_register_corrupted,
		i_regulator_fault, i_regulator_steady,
		i_regulator_disable};

	level_sync #(.WIDTH(NSYNC)) u_sync (
		.i_mclk(i_mclk),
		.i_sys_rst(i_sys_rst),
		.lv(lv)
	);

	assign corrupted = lv.clean[3];
	assign regulator_disable = lv.clean[0];

	// ****************************************
	// mask register
	// ****************************************
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			interrupt_mask_q <= `MASK_RESET;
		end else if (i_wr_en && i_addr == `ADDR_INTERRUPT_MASK) begin
			interrupt_mask_q <= i_wr_data & `MASK_USED_BITS;
		end
	end

	// ****************************************
	// live status
	// ****************************************
	always_comb begin
		live_status = `LIVE_STATUS_RESET;
		// comparators already apply their own hysteresis thresholds
		live_status[`BIT_PRI_LOW] = lv.clean[10];
		live_status[`BIT_SEC_LOW] = lv.clean[9];
		live_status[`BIT_SEC_FAULT] = lv.clean[8];
		live_status[`BIT_PRI_FAULT] = lv.clean[7];
		live_status[`BIT_SUP_WARN] = lv.clean[6];
		live_status[`BIT_SUP_UV] = lv.clean[5];
		live_status[`BIT_THERM] = lv.clean[4];
	end

	// ****************************************
	// integrity and regulator status
	// ****************************************
	always_comb begin
		integrity_status = `INTEGRITY_RESET;
		integrity_status[`BIT_CORRUPT] = corrupted;
		integrity_status[`BIT_REG_FAULT] = lv.clean[2];
		integrity_status[`BIT_REG_READY] = regulator_disable ||
			(lv.clean[1] && !lv.clean[2]);
	end

	// ****************************************
	// read path
	// ****************************************
	always_comb begin
		case (i_addr)
			`ADDR_INTERRUPT_MASK: rd_data_d = interrupt_mask_q;
			`ADDR_LIVE_STATUS: rd_data_d = live_status;
			`ADDR_INTEGRITY_STATUS: rd_data_d = integrity_status;
			default: rd_data_d = 8'h00;
		endcase
	end

	// reads have no side effect on status bits
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_rd_data <= 8'h00;
		end else if (i_rd_en) begin
			o_rd_data <= rd_data_d;
		end
	end

	// ****************************************
	// interrupt output
	// ****************************************
	// flags arrive latched from the flag register; the mask never reaches it
	always_comb begin
		irq_n_d = 1'b1;
		if (i_flags[`BIT_WAKE] && !interrupt_mask_q[`BIT_WAKE]) begin
			irq_n_d = 1'b0;
		end
		if (i_flags[`BIT_SEC_FAULT] && !interrupt_mask_q[`BIT_SEC_FAULT]) begin
			irq_n_d = 1'b0;
		end
		if (i_flags[`BIT_PRI_FAULT] && !interrupt_mask_q[`BIT_PRI_FAULT]) begin
			irq_n_d = 1'b0;
		end
		if (i_flags[`BIT_SUP_WARN] && !interrupt_mask_q[`BIT_SUP_WARN]) begin
			irq_n_d = 1'b0;
		end
		if (i_flags[`BIT_SUP_UV] && !interrupt_mask_q[`BIT_SUP_UV]) begin
			irq_n_d = 1'b0;
		end
		if (i_flags[`BIT_THERM] && !interrupt_mask_q[`BIT_THERM]) begin
			irq_n_d = 1'b0;
		end
		// top flag (not ready) cannot be masked
		if (i_flags[7]) begin
			irq_n_d = 1'b0;
		end
	end

	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_irq_n <= 1'b1;
		end else begin
			o_irq_n <= irq_n_d;
		end
	end

	// ****************************************
	// corruption safe state
	// ****************************************
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_drivers_enable <= 1'b0;
			o_io_output_enable <= 1'b0;
			o_ldo33_force_on <= 1'b0;
			o_clock_out_force_on <= 1'b0;
		end else begin
			o_drivers_enable <= !corrupted;
			o_io_output_enable <= !corrupted;
			o_ldo33_force_on <= corrupted;
			o_clock_out_force_on <= corrupted;
		end
	end

	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_regulator_enable <= 1'b0;
		end else begin
			o_regulator_enable <= corrupted || !regulator_disable;
		end
	end
endmodule

//--- tb/irq_status_checker.sv
// port assertions for the mask and status bank
// assumes binding into irq_status_regs, one clock domain
`timescale 1ns/1ns
module irq_status_checker (
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wr_data,
	input wire logic [7:0] o_rd_data,
	input wire logic [7:0] i_flags,
	input wire logic i_register_corrupted,
	input wire logic i_regulator_disable,
	input wire logic o_irq_n,
	input wire logic o_drivers_enable,
	input wire logic o_io_output_enable,
	input wire logic o_ldo33_force_on,
	input wire logic o_regulator_enable,
	input wire logic o_clock_out_force_on
);
	// ****************************************
	// shadow of the mask register
	// ****************************************
	logic [7:0] mask_q;
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			mask_q <= 8'h00;
		end else if (i_wr_en && i_addr == 4'h1) begin
			mask_q <= i_wr_data & 8'h7D;
		end
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);
	a_irq_gate: assert property (!$past(i_sys_rst) |->
		o_irq_n == !(|($past(i_flags) & ~$past(mask_q) & 8'hFD)))
		else $error("irq level wrong");
	a_mask_read: assert property (i_rd_en && i_addr == 4'h1 |=>
		o_rd_data == mask_q) else $error("mask readback wrong");
	a_unmapped_zero: assert property (i_rd_en &&
		(i_addr == 4'h0 || i_addr > 4'h3) |=> o_rd_data == 8'h00)
		else $error("unmapped read not zero");
	a_unused_zero: assert property (i_rd_en && i_addr == 4'h3 |=>
		o_rd_data[6:2] == 5'h00) else $error("unused bits not zero");
	a_safe_state: assert property (i_register_corrupted[*5] |->
		!o_drivers_enable && !o_io_output_enable && o_ldo33_force_on
		&& o_clock_out_force_on && o_regulator_enable)
		else $error("safe state missing");
	a_normal_state: assert property ((!i_register_corrupted)[*5] |->
		o_drivers_enable && o_io_output_enable && !o_ldo33_force_on
		&& !o_clock_out_force_on) else $error("forced state stuck");
	a_regulator_off: assert property (
		(!i_register_corrupted && i_regulator_disable)[*5]
		|-> !o_regulator_enable) else $error("regulator not off");
	a_ready_forced: assert property (i_regulator_disable[*5] ##0
		(i_rd_en && i_addr == 4'h3) |=> o_rd_data[0])
		else $error("ready bit not forced");
endmodule
bind irq_status_regs irq_status_checker u_chk (.*);

//--- tb/irq_host_model.sv
// host controller model issuing register strobes
// assumes one-cycle strobes taken on the rising edge
`timescale 1ns/1ns
module irq_host_model (
	input wire logic i_mclk,
	input wire logic [7:0] i_rd_data,
	output logic o_wr_en,
	output logic o_rd_en,
	output logic [3:0] o_addr,
	output logic [7:0] o_wr_data
);
	// ****************************************
	// bus cycles, driven on the falling edge
	// ****************************************
	initial begin
		o_wr_en = 1'h0;
		o_rd_en = 1'h0;
		o_addr = 4'h0;
		o_wr_data = 8'h00;
	end
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge i_mclk);
		o_addr = a;
		o_wr_data = d;
		o_wr_en = 1'h1;
		@(negedge i_mclk);
		o_wr_en = 1'h0;
		o_wr_data = ~d;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(negedge i_mclk);
		o_addr = a;
		o_rd_en = 1'h1;
		@(negedge i_mclk);
		o_rd_en = 1'h0;
		o_addr = ~a;
		@(negedge i_mclk);
		d = i_rd_data;
	endtask
endmodule

//--- tb/irq_mask_and_status_regs_tb.sv
// self-checking bench for the mask and status bank
// assumes the host model drives the register strobes
`timescale 1ns/1ns
module irq_mask_and_status_regs_tb;
	logic i_mclk, i_sys_rst, i_wr_en, i_rd_en;
	logic o_irq_n, o_drivers_enable, o_io_output_enable;
	logic o_ldo33_force_on, o_regulator_enable, o_clock_out_force_on;
	logic [3:0] i_addr;
	logic [7:0] i_wr_data, o_rd_data, i_flags, got;
	logic [10:0] lv;
	logic [7:0] outs;
	int miscompares, checked, cycles;
	assign outs = {2'h0, o_irq_n, o_drivers_enable, o_io_output_enable,
		o_ldo33_force_on, o_regulator_enable, o_clock_out_force_on};
	irq_host_model u_host (.i_mclk(i_mclk), .i_rd_data(o_rd_data),
		.o_wr_en(i_wr_en), .o_rd_en(i_rd_en), .o_addr(i_addr),
		.o_wr_data(i_wr_data));
	irq_status_regs u_dut (.i_primary_line_low(lv[10]),
		.i_secondary_line_low(lv[9]), .i_secondary_driver_fault(lv[8]),
		.i_primary_driver_fault(lv[7]), .i_supply_below_warning(lv[6]),
		.i_supply_undervoltage(lv[5]), .i_die_temp_warning(lv[4]),
		.i_register_corrupted(lv[3]), .i_regulator_fault(lv[2]),
		.i_regulator_steady(lv[1]), .i_regulator_disable(lv[0]), .*);
	// ****************************************
	// checks and scenarios
	// ****************************************
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic t_mask;
		u_host.rd(4'h1, got);
		chk("mask reset", 8'h00, got);
		u_host.wr(4'h1, 8'hFF);
		u_host.rd(4'h1, got);
		chk("mask", 8'h7D, got);
		u_host.wr(4'h2, 8'hFF);
		u_host.rd(4'h2, got);
		chk("status write", 8'h00, got);
		u_host.rd(4'h5, got);
		chk("unmapped", 8'h00, got);
	endtask
	task automatic t_irq;
		int b;
		for (int i = 0; i < 8; i++) begin
			b = (i == 1) ? 7 : i;
			i_flags = 8'h01 << b;
			u_host.wr(4'h1, 8'h00);
			repeat (2) @(negedge i_mclk);
			chk("irq open", 8'h1A, outs);
			u_host.wr(4'h1, 8'h01 << b);
			repeat (2) @(negedge i_mclk);
			chk("irq masked", (b == 7) ? 8'h1A : 8'h3A, outs);
		end
		i_flags = 8'h02;
		u_host.wr(4'h1, 8'h00);
		repeat (2) @(negedge i_mclk);
		chk("irq spare", 8'h3A, outs);
		i_flags = 8'h00;
	endtask
	task automatic t_status;
		for (int i = 0; i < 7; i++) begin
			lv = 11'h400 >> i;
			repeat (4) @(negedge i_mclk);
			for (int r = 0; r < 2; r++) begin
				u_host.rd(4'h2, got);
				chk("live", (i == 6) ? 8'h01 : 8'h80 >> i, got);
			end
		end
	endtask
	task automatic t_integrity;
		logic [10:0] cv [5] = '{11'h001, 11'h002, 11'h006, 11'h008, 11'h000};
		logic [7:0] ev [5] = '{8'h01, 8'h01, 8'h02, 8'h80, 8'h00};
		logic [7:0] ov [5] = '{8'h38, 8'h3A, 8'h3A, 8'h27, 8'h3A};
		for (int i = 0; i < 5; i++) begin
			lv = cv[i];
			repeat (5) @(negedge i_mclk);
			u_host.rd(4'h3, got);
			chk("integrity", ev[i], got);
			chk("outputs", ov[i], outs);
		end
	endtask
	task automatic final_report;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		i_mclk = 1'h0;
		forever #5 i_mclk = ~i_mclk;
	end
	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			final_report;
		end
	end
	initial begin
		i_sys_rst = 1'h1;
		i_flags = 8'h00;
		lv = 11'h000;
		repeat (12) @(posedge i_mclk);
		@(negedge i_mclk);
		i_sys_rst = 1'h0;
		t_mask;
		t_irq;
		t_status;
		t_integrity;
		final_report;
	end
endmodule
